// file: verilog/dual_timer_counter_unit.sv
// two timer/counters with shared control and mode registers on a plain port
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] timer b matches timer a in modes 0-2; its mode 3 holds the count
// [R2] timer b uses mode bits 7:4 and control bits 2, 3, 6, 7
// [R3] ungated timer b counts its low byte while its run bit is set
// [R4] gated timer b counts only with run bit set and its irq pin high; the code ignores b run while timer a is in mode 3
// [R5] gated timer a counts only with run bit set and its irq pin high
// [R6] source select picks peripheral cycles or falling edges on count pin
// [R7] mode field 00 13-bit, 01 16-bit, 10 reload, 11 mode 3
// [R8] mode 0: 5-bit prescaler in low byte feeds the high byte
// [R9] mode 1: low and high bytes form one 16-bit counter
// [R10] mode 2: low byte reloads from unchanged high byte and sets overflow
// [R11] timer b in mode 3 stops and keeps its count
// [R12] timer a mode 3: low byte normal, high byte uses b run and flag
// [R13] while timer a is in mode 3 timer b leaves b run and flag alone
// [R14] software uses timer b without interrupt, toggling mode 3 to stop it
// [R15] rollover to zero sets overflow flag and raises its request
// [R16] overflow flag clears when the processor vectors to that interrupt
// [R17] request reaches processor only with timer enable and global enable
// [R18] control bits: b flag 7, b run 6, a flag 5, a run 4
// [R19] type bit clear means low level trigger, set means falling edge
// [R20] irq flags set on detection, hardware clears them only edge-triggered
// [R21] software stops a timer before changing its mode
// [R22] timer b overflow goes out as the serial baud source
// [R23] timer source advances once per six-clock peripheral cycle
// [R24] count pin sampled each peripheral cycle; high then low counts
// [R25] software may read bytes anytime, stops timer before presetting
// [R26] all registers reset to zero; hardware flag set beats software write
module dual_timer_counter_unit (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // pins
  input wire logic ext_irq_a_pin_n,
  input wire logic ext_irq_b_pin_n,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  // interrupt controller side
  input wire logic timer_a_irq_enable,
  input wire logic timer_b_irq_enable,
  input wire logic global_irq_enable,
  input wire logic timer_a_vector_ack,
  input wire logic timer_b_vector_ack,
  input wire logic ext_irq_a_vector_ack,
  input wire logic ext_irq_b_vector_ack,
  output logic timer_a_irq,
  output logic timer_b_irq,
  output logic ext_irq_a_req,
  output logic ext_irq_b_req,
  // serial port
  output logic baud_tick
);
  localparam int DIV_W = $clog2(timer_pkg::PER_CYCLE_CLOCKS);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(timer_pkg::PER_CYCLE_CLOCKS - 1);

  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [7:0] mode_q;
  logic [DIV_W-1:0] div_q;
  logic tick;
  logic [7:0] a_low;
  logic [7:0] a_high;
  logic [7:0] b_low;
  logic [7:0] b_high;
  logic a_ovf;
  logic a_ovf_split;
  logic b_ovf;
  logic b_ovf_unused;
  logic a_fell;
  logic b_fell;
  logic irq_a_last_q;
  logic irq_b_last_q;
  logic baud_q;
  logic [7:0] rdata_q;

  // decode
  logic wr_control;
  logic wr_mode;
  logic wr_a_low;
  logic wr_a_high;
  logic wr_b_low;
  logic wr_b_high;
  assign wr_control = wr_en && (addr == timer_pkg::ADDR_CONTROL);
  assign wr_mode = wr_en && (addr == timer_pkg::ADDR_MODE);
  assign wr_a_low = wr_en && (addr == timer_pkg::ADDR_A_LOW);
  assign wr_a_high = wr_en && (addr == timer_pkg::ADDR_A_HIGH);
  assign wr_b_low = wr_en && (addr == timer_pkg::ADDR_B_LOW);
  assign wr_b_high = wr_en && (addr == timer_pkg::ADDR_B_HIGH);

  // mode fields
  logic [3:0] a_nib;
  logic [3:0] b_nib;
  timer_pkg::timer_mode_e a_mode;
  timer_pkg::timer_mode_e b_mode;
  assign a_nib = mode_q[3:0];
  assign b_nib = mode_q[timer_pkg::MODE_B_BASE +: 4]; // [R2]
  assign a_mode = timer_pkg::timer_mode_e'(a_nib[timer_pkg::MODE_HI:timer_pkg::MODE_LO]); // [R7]
  assign b_mode = timer_pkg::timer_mode_e'(b_nib[timer_pkg::MODE_HI:timer_pkg::MODE_LO]); // [R7]

  logic a_split;
  assign a_split = a_mode == timer_pkg::MODE_SPLIT;

  // peripheral cycle divider
  assign tick = div_q == DIV_LAST; // [R23]
  always_ff @(posedge core_clk) begin
    if (rst) div_q <= '0;
    else div_q <= tick ? '0 : div_q + DIV_W'(1);
  end

  edge_sampler u_a_edge (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .pin(timer_a_count_pin),
    .fell(a_fell) // [R24]
  );
  edge_sampler u_b_edge (
    .core_clk(core_clk),
    .rst(rst),
    .tick(tick),
    .pin(timer_b_count_pin),
    .fell(b_fell)
  );

  // run enables
  logic a_run;
  logic b_run;
  logic a_gate_ok;
  logic b_gate_ok;
  logic a_inc;
  logic b_inc;
  logic a_high_inc;
  assign a_run = control_q[timer_pkg::CTL_A_RUN]; // [R18]
  assign b_run = control_q[timer_pkg::CTL_B_RUN]; // [R18]
  assign a_gate_ok = ~a_nib[timer_pkg::MODE_GATE] | ext_irq_a_pin_n; // [R5]
  assign b_gate_ok = ~b_nib[timer_pkg::MODE_GATE] | ext_irq_b_pin_n; // [R4]
  assign a_inc = a_run && a_gate_ok &&
    (a_nib[timer_pkg::MODE_SOURCE] ? a_fell : tick); // [R6]
  // in split mode timer b runs without the run bit, stopped only by its mode 3 or by its gate with pin b low
  assign b_inc = (a_split ? 1'b1 : b_run) && b_gate_ok &&
    (b_nib[timer_pkg::MODE_SOURCE] ? b_fell : tick); // [R3] [R13]
  assign a_high_inc = a_split && b_run && tick; // [R12]

  timer_core #(
    .IS_A(1'b1)
  ) u_timer_a (
    .core_clk(core_clk),
    .rst(rst),
    .inc_low(a_inc),
    .inc_high_split(a_high_inc),
    .mode(a_mode), // [R8] [R9] [R10]
    .wr_low(wr_a_low),
    .wr_high(wr_a_high),
    .wdata(wdata),
    .low_q(a_low),
    .high_q(a_high),
    .ovf(a_ovf),
    .ovf_split(a_ovf_split)
  );
  // not split capable, so its mode 3 is a hold
  timer_core #(
    .IS_A(1'b0)
  ) u_timer_b (
    .core_clk(core_clk),
    .rst(rst),
    .inc_low(b_inc),
    .inc_high_split(1'b0),
    .mode(b_mode),
    .wr_low(wr_b_low),
    .wr_high(wr_b_high),
    .wdata(wdata),
    .low_q(b_low),
    .high_q(b_high),
    .ovf(b_ovf),
    .ovf_split(b_ovf_unused)
  ); // [R1] [R11]

  // external interrupt detection
  logic a_type;
  logic b_type;
  logic a_detect;
  logic b_detect;
  assign a_type = control_q[timer_pkg::CTL_A_IRQ_TYPE];
  assign b_type = control_q[timer_pkg::CTL_B_IRQ_TYPE];
  assign a_detect = a_type ? (irq_a_last_q & ~ext_irq_a_pin_n) : ~ext_irq_a_pin_n; // [R19]
  assign b_detect = b_type ? (irq_b_last_q & ~ext_irq_b_pin_n) : ~ext_irq_b_pin_n; // [R19]

  // flag sources; timer b's overflow does not touch its flag in split mode
  logic b_flag_set;
  assign b_flag_set = a_split ? a_ovf_split : b_ovf; // [R12] [R13]

  // control register next value: software, then hardware clears, then sets
  always_comb begin
    control_d = control_q;
    if (wr_control) control_d = wdata;
    if (timer_a_vector_ack) control_d[timer_pkg::CTL_A_OVF] = 1'b0; // [R16]
    if (timer_b_vector_ack) control_d[timer_pkg::CTL_B_OVF] = 1'b0; // [R16]
    if (ext_irq_a_vector_ack && a_type) control_d[timer_pkg::CTL_A_IRQ_FLAG] = 1'b0; // [R20]
    if (ext_irq_b_vector_ack && b_type) control_d[timer_pkg::CTL_B_IRQ_FLAG] = 1'b0; // [R20]
    // level mode flag follows the pin
    if (!a_type) control_d[timer_pkg::CTL_A_IRQ_FLAG] = 1'b0;
    if (!b_type) control_d[timer_pkg::CTL_B_IRQ_FLAG] = 1'b0;
    if (a_detect) control_d[timer_pkg::CTL_A_IRQ_FLAG] = 1'b1; // [R20]
    if (b_detect) control_d[timer_pkg::CTL_B_IRQ_FLAG] = 1'b1; // [R20]
    if (a_ovf) control_d[timer_pkg::CTL_A_OVF] = 1'b1; // [R15] [R26]
    if (b_flag_set) control_d[timer_pkg::CTL_B_OVF] = 1'b1; // [R15] [R26]
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      control_q <= timer_pkg::RESET_VALUE; // [R26]
      mode_q <= timer_pkg::RESET_VALUE; // [R26]
      irq_a_last_q <= 1'b1;
      irq_b_last_q <= 1'b1;
      baud_q <= 1'b0;
    end else begin
      control_q <= control_d;
      if (wr_mode) mode_q <= wdata;
      irq_a_last_q <= ext_irq_a_pin_n;
      irq_b_last_q <= ext_irq_b_pin_n;
      baud_q <= b_ovf; // [R22]
    end
  end

  // requests
  assign timer_a_irq = control_q[timer_pkg::CTL_A_OVF] &&
    timer_a_irq_enable && global_irq_enable; // [R17]
  assign timer_b_irq = control_q[timer_pkg::CTL_B_OVF] &&
    timer_b_irq_enable && global_irq_enable; // [R17]
  assign ext_irq_a_req = control_q[timer_pkg::CTL_A_IRQ_FLAG];
  assign ext_irq_b_req = control_q[timer_pkg::CTL_B_IRQ_FLAG];
  assign baud_tick = baud_q;

  // read mux, registered so data stand one cycle after the strobe
  logic [7:0] rd_mux;
  assign rd_mux = (addr == timer_pkg::ADDR_CONTROL) ? control_q :
                  (addr == timer_pkg::ADDR_MODE) ? mode_q :
                  (addr == timer_pkg::ADDR_A_LOW) ? a_low :
                  (addr == timer_pkg::ADDR_B_LOW) ? b_low :
                  (addr == timer_pkg::ADDR_A_HIGH) ? a_high :
                  (addr == timer_pkg::ADDR_B_HIGH) ? b_high : 8'h00; // [R25]
  always_ff @(posedge core_clk) begin
    if (rst) rdata_q <= 8'h00;
    else rdata_q <= rd_en ? rd_mux : 8'h00;
  end
  assign rdata = rdata_q;
endmodule
`default_nettype wire

// file: verilog/timer_pkg.sv
// register map, field positions and timing constants of the dual timer unit
package timer_pkg;
  localparam logic [7:0] ADDR_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_MODE = 8'h89;
  localparam logic [7:0] ADDR_A_LOW = 8'h8a;
  localparam logic [7:0] ADDR_B_LOW = 8'h8b;
  localparam logic [7:0] ADDR_A_HIGH = 8'h8c;
  localparam logic [7:0] ADDR_B_HIGH = 8'h8d;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // control register fields
  localparam int CTL_B_OVF = 7;
  localparam int CTL_B_RUN = 6;
  localparam int CTL_A_OVF = 5;
  localparam int CTL_A_RUN = 4;
  localparam int CTL_B_IRQ_FLAG = 3;
  localparam int CTL_B_IRQ_TYPE = 2;
  localparam int CTL_A_IRQ_FLAG = 1;
  localparam int CTL_A_IRQ_TYPE = 0;
  // mode register fields, timer b nibble sits at this offset
  localparam int MODE_B_BASE = 4;
  localparam int MODE_GATE = 3;
  localparam int MODE_SOURCE = 2;
  localparam int MODE_HI = 1;
  localparam int MODE_LO = 0;
  // clocks per peripheral cycle
  localparam int PER_CYCLE_CLOCKS = 6;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } timer_mode_e;
endpackage

// file: verilog/edge_sampler.sv
// samples a pin once per peripheral cycle and reports falling transitions
`timescale 1ns/1ps
`default_nettype none
module edge_sampler (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // sampling
  input wire logic tick,
  input wire logic pin,
  output logic fell
);
  logic last_q;
  logic now_q;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_q <= 1'b0;
      now_q <= 1'b0;
    end else if (tick) begin
      last_q <= now_q;
      now_q <= pin;
    end
  end
  // high sample then low sample
  assign fell = tick & last_q & ~now_q;
endmodule
`default_nettype wire

// file: verilog/timer_core.sv
// one timer's count logic in modes 0, 1 and 2, plus split and hold
`timescale 1ns/1ps
`default_nettype none
module timer_core #(
  parameter bit IS_A = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // count enables
  input wire logic inc_low,
  input wire logic inc_high_split,
  input wire timer_pkg::timer_mode_e mode,
  // software writes
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  // state
  output logic [7:0] low_q,
  output logic [7:0] high_q,
  output logic ovf,
  output logic ovf_split
);
  logic [7:0] low_d;
  logic [7:0] high_d;
  logic low_wrap;
  logic pre_wrap;
  logic high_wrap;
  logic split;
  assign split = IS_A && (mode == timer_pkg::MODE_SPLIT);
  assign low_wrap = inc_low && (low_q == 8'hff);
  assign pre_wrap = inc_low && (low_q[4:0] == 5'h1f);
  assign high_wrap = high_q == 8'hff;
  always_comb begin
    low_d = low_q;
    high_d = high_q;
    ovf = 1'b0;
    ovf_split = 1'b0;
    unique case (mode)
      timer_pkg::MODE_13BIT: begin
        // upper three low bits left alone
        if (inc_low) low_d = {low_q[7:5], low_q[4:0] + 5'h01}; // [R8]
        if (pre_wrap) high_d = high_q + 8'h01; // [R8]
        ovf = pre_wrap && high_wrap; // [R15]
      end
      timer_pkg::MODE_16BIT: begin
        if (inc_low) low_d = low_q + 8'h01; // [R9]
        if (low_wrap) high_d = high_q + 8'h01; // [R9]
        ovf = low_wrap && high_wrap; // [R15]
      end
      timer_pkg::MODE_RELOAD: begin
        if (inc_low) low_d = low_wrap ? high_q : low_q + 8'h01; // [R10]
        ovf = low_wrap; // [R10]
      end
      timer_pkg::MODE_SPLIT: begin
        if (split) begin
          if (inc_low) low_d = low_q + 8'h01; // [R12]
          ovf = low_wrap; // [R12]
          if (inc_high_split) high_d = high_q + 8'h01; // [R12]
          ovf_split = inc_high_split && high_wrap; // [R12]
        end
        // timer b holds its count here
      end
    endcase
    if (wr_low) low_d = wdata;
    if (wr_high) high_d = wdata;
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      low_q <= timer_pkg::RESET_VALUE;
      high_q <= timer_pkg::RESET_VALUE;
    end else begin
      low_q <= low_d;
      high_q <= high_d;
    end
  end
endmodule
`default_nettype wire

// file: tb/dual_timer_counter_unit_props.sv
// port-level assertions of the dual timer unit
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_unit_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  // pins and interrupt side
  input wire logic ext_irq_a_pin_n,
  input wire logic timer_a_irq_enable,
  input wire logic timer_b_irq_enable,
  input wire logic global_irq_enable,
  input wire logic timer_a_vector_ack,
  input wire logic timer_a_irq,
  input wire logic timer_b_irq,
  input wire logic ext_irq_a_req,
  input wire logic baud_tick
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_irq_a_gate: assert property (
    timer_a_irq |-> timer_a_irq_enable && global_irq_enable) else $error("timer a irq ungated");
  chk_irq_b_gate: assert property (
    timer_b_irq |-> timer_b_irq_enable && global_irq_enable) else $error("timer b irq ungated");
  chk_ext_a_cause: assert property (
    $rose(ext_irq_a_req) |-> $past(ext_irq_a_pin_n) == 1'b0 || $past(wr_en))
    else $error("ext flag a set without a low pin");
  // ticks come once per peripheral cycle, so overflows cannot be closer
  chk_baud_spacing: assert property (
    baud_tick |=> !baud_tick [*5]) else $error("baud ticks too close");
  chk_ack_clears: assert property (
    timer_a_vector_ack && !wr_en |=> !timer_a_irq) else $error("ack left flag a set");
  chk_irq_holds: assert property (
    timer_a_irq && !timer_a_vector_ack && !wr_en ##1 timer_a_irq_enable && global_irq_enable
    |-> timer_a_irq) else $error("flag a dropped without ack");
  chk_rdata_idle: assert property (
    !$past(rd_en) |-> rdata == 8'h00) else $error("read data outside read slot");
  chk_mode_readback: assert property (
    wr_en && addr == timer_pkg::ADDR_MODE ##1 rd_en && addr == timer_pkg::ADDR_MODE
    |=> rdata == $past(wdata, 2)) else $error("mode register lost a write");
  chk_reset_clean: assert property (
    $fell(rst) |-> rdata == 8'h00 && !timer_a_irq && !timer_b_irq && !baud_tick)
    else $error("outputs not quiet after reset");
endmodule
`default_nettype wire

// file: tb/cpu_vector_model.sv
// cpu interrupt side: vectors to a pending timer request after a delay
`timescale 1ns/1ps
`default_nettype none
module cpu_vector_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // requests and response delay
  input wire logic [1:0] irq,
  input wire logic [3:0] delay,
  output logic [1:0] ack
);
  logic [3:0] wait_q [2];
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      ack[i] <= 1'b0;
      if (rst || !irq[i] || ack[i]) begin
        wait_q[i] <= 4'h0;
      end else if (wait_q[i] == delay) begin
        ack[i] <= 1'b1;
      end else begin
        wait_q[i] <= wait_q[i] + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/test_dual_timer_counter_unit.sv
// self-checking bench of the dual timer unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module test_dual_timer_counter_unit;
  logic core_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic ext_irq_a_pin_n = 1'b1, ext_irq_b_pin_n = 1'b1;
  logic timer_a_count_pin = 1'b1, timer_b_count_pin = 1'b1;
  logic timer_a_irq_enable = 1'b0, timer_b_irq_enable = 1'b0, global_irq_enable = 1'b0;
  logic ext_irq_a_vector_ack = 1'b0, ext_irq_b_vector_ack = 1'b0;
  logic timer_a_vector_ack, timer_b_vector_ack, timer_a_irq, timer_b_irq;
  logic ext_irq_a_req, ext_irq_b_req, baud_tick;
  logic [1:0] ack;
  logic [3:0] ack_delay = 4'h3;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
  int err_total = 0, num_checks = 0, bauds = 0;
  assign timer_a_vector_ack = ack[0];
  assign timer_b_vector_ack = ack[1];
  dual_timer_counter_unit i_dual_timer_counter_unit (.core_clk, .rst, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .ext_irq_a_pin_n, .ext_irq_b_pin_n, .timer_a_count_pin, .timer_b_count_pin,
    .timer_a_irq_enable, .timer_b_irq_enable, .global_irq_enable, .timer_a_vector_ack,
    .timer_b_vector_ack, .ext_irq_a_vector_ack, .ext_irq_b_vector_ack, .timer_a_irq,
    .timer_b_irq, .ext_irq_a_req, .ext_irq_b_req, .baud_tick);
  cpu_vector_model i_cpu_vector_model (.core_clk, .rst, .irq({timer_b_irq, timer_a_irq}),
    .delay(ack_delay), .ack(ack));
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (baud_tick === 1'b1) bauds++;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    v = rdata;
    @(posedge core_clk);
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    `CHK(v, e)
  endtask
  // levels held 12 clocks so each one is sampled at least once
  task automatic fall_b(input int n);
    repeat (n) begin
      timer_b_count_pin <= 1'b0;
      wait_clk(12);
      timer_b_count_pin <= 1'b1;
      wait_clk(12);
    end
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    wait_clk(3);
    rst <= 1'b0;
    wait_clk(1);
    for (int i = 0; i < 6; i++) expect_reg(8'h88 + 8'(i), 8'h00);
    wr(8'h90, 8'hff);
    expect_reg(8'h90, 8'h00);
    addr <= timer_pkg::ADDR_MODE;
    wdata <= 8'h21;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    expect_reg(timer_pkg::ADDR_MODE, 8'h21);
    // mode 1 on timer a, rolls over near the start
    wr(timer_pkg::ADDR_MODE, 8'h01);
    wr(timer_pkg::ADDR_A_LOW, 8'hfc);
    wr(timer_pkg::ADDR_A_HIGH, 8'hff);
    wr(timer_pkg::ADDR_CONTROL, 8'h10);
    wait_clk(60);
    wr(timer_pkg::ADDR_CONTROL, 8'h20);
    rd(timer_pkg::ADDR_A_LOW);
    `CHK(v inside {[8'h04:8'h08]}, 1'b1)
    expect_reg(timer_pkg::ADDR_A_HIGH, 8'h00);
    expect_reg(timer_pkg::ADDR_CONTROL, 8'h20);
    `CHK(timer_a_irq, 1'b0)
    timer_a_irq_enable <= 1'b1;
    global_irq_enable <= 1'b1;
    wait_clk(2);
    `CHK(timer_a_irq, 1'b1)
    wait_clk(8);
    expect_reg(timer_pkg::ADDR_CONTROL, 8'h00);
    // mode 0: five-bit prescaler feeds the high byte
    wr(timer_pkg::ADDR_MODE, 8'h00);
    wr(timer_pkg::ADDR_A_LOW, 8'hfe);
    wr(timer_pkg::ADDR_A_HIGH, 8'h10);
    wr(timer_pkg::ADDR_CONTROL, 8'h10);
    wait_clk(60);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    rd(timer_pkg::ADDR_A_LOW);
    `CHK(v inside {[8'he6:8'hea]}, 1'b1)
    expect_reg(timer_pkg::ADDR_A_HIGH, 8'h11);
    // timer b auto-reload, baud source
    global_irq_enable <= 1'b0;
    bauds = 0;
    wr(timer_pkg::ADDR_MODE, 8'h20);
    wr(timer_pkg::ADDR_B_HIGH, 8'hfd);
    wr(timer_pkg::ADDR_B_LOW, 8'hfd);
    wr(timer_pkg::ADDR_CONTROL, 8'h40);
    wait_clk(60);
    wr(timer_pkg::ADDR_CONTROL, 8'h80);
    expect_reg(timer_pkg::ADDR_B_HIGH, 8'hfd);
    rd(timer_pkg::ADDR_B_LOW);
    `CHK(v >= 8'hfd, 1'b1)
    `CHK(bauds inside {[2:4]}, 1'b1)
    expect_reg(timer_pkg::ADDR_CONTROL, 8'h80);
    // gated counter on timer b, level-triggered pin b
    wr(timer_pkg::ADDR_MODE, 8'hc1);
    wr(timer_pkg::ADDR_B_LOW, 8'h00);
    ext_irq_b_pin_n <= 1'b0;
    wr(timer_pkg::ADDR_CONTROL, 8'h40);
    fall_b(3);
    `CHK(ext_irq_b_req, 1'b1)
    expect_reg(timer_pkg::ADDR_B_LOW, 8'h00);
    ext_irq_b_pin_n <= 1'b1;
    wait_clk(2);
    `CHK(ext_irq_b_req, 1'b0)
    fall_b(5);
    wait_clk(24);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    expect_reg(timer_pkg::ADDR_B_LOW, 8'h05);
    // edge-triggered pin a, cleared on vectoring
    wr(timer_pkg::ADDR_CONTROL, 8'h01);
    ext_irq_a_pin_n <= 1'b0;
    wait_clk(3);
    ext_irq_a_pin_n <= 1'b1;
    wait_clk(3);
    `CHK(ext_irq_a_req, 1'b1)
    ext_irq_a_vector_ack <= 1'b1;
    @(posedge core_clk);
    ext_irq_a_vector_ack <= 1'b0;
    wait_clk(2);
    `CHK(ext_irq_a_req, 1'b0)
    // gated timer a
    wr(timer_pkg::ADDR_MODE, 8'h09);
    wr(timer_pkg::ADDR_A_LOW, 8'h00);
    ext_irq_a_pin_n <= 1'b0;
    wr(timer_pkg::ADDR_CONTROL, 8'h10);
    wait_clk(60);
    expect_reg(timer_pkg::ADDR_A_LOW, 8'h00);
    ext_irq_a_pin_n <= 1'b1;
    wait_clk(60);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    rd(timer_pkg::ADDR_A_LOW);
    `CHK(v inside {[8'h08:8'h0c]}, 1'b1)
    // split timer a, then timer b held by its mode 3
    wr(timer_pkg::ADDR_MODE, 8'h13);
    wr(timer_pkg::ADDR_A_HIGH, 8'h00);
    wr(timer_pkg::ADDR_A_LOW, 8'h00);
    wr(timer_pkg::ADDR_CONTROL, 8'h40);
    wait_clk(60);
    wr(timer_pkg::ADDR_CONTROL, 8'h00);
    rd(timer_pkg::ADDR_A_HIGH);
    `CHK(v inside {[8'h08:8'h0c]}, 1'b1)
    expect_reg(timer_pkg::ADDR_A_LOW, 8'h00);
    wr(timer_pkg::ADDR_MODE, 8'h33);
    rd(timer_pkg::ADDR_B_LOW);
    wait_clk(30);
    expect_reg(timer_pkg::ADDR_B_LOW, v);
    results();
  end
endmodule
bind dual_timer_counter_unit dual_timer_counter_unit_props i_dual_timer_counter_unit_props (
  .core_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .ext_irq_a_pin_n, .timer_a_irq_enable,
  .timer_b_irq_enable, .global_irq_enable, .timer_a_vector_ack, .timer_a_irq, .timer_b_irq,
  .ext_irq_a_req, .baud_tick);
`default_nettype wire
